// ==== src/otp_shadow_mem.sv ====
`timescale 1ns/10ps
`default_nettype none

module otp_shadow_mem #(
    parameter int ADDR_WIDTH = 8,
    parameter int DATA_WIDTH = 8
) (
    // clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rstn_i,
    // write port, used only by the boot copy
    input  wire logic                  wr_en_i,
    input  wire logic [ADDR_WIDTH-1:0] wr_addr_i,
    input  wire logic [DATA_WIDTH-1:0] wr_data_i,
    // read port, data registered
    input  wire logic [ADDR_WIDTH-1:0] rd_addr_i,
    output logic      [DATA_WIDTH-1:0] rd_data_o
);

    localparam int DEPTH = 1 << ADDR_WIDTH;

    logic [DATA_WIDTH-1:0] mem_q [DEPTH];
    logic [DATA_WIDTH-1:0] rd_data_q;
    logic [DATA_WIDTH-1:0] rd_data_d;

    always_comb begin
        rd_data_d = mem_q[rd_addr_i];
    end

    // storage has no reset; the boot copy fills every entry
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data_o = rd_data_q;

endmodule // otp_shadow_mem

`default_nettype wire

// ==== src/pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    // asynchronous levels in, synchronous levels out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    // the first stage feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

endmodule // pin_sync

`default_nettype wire

// ==== src/safe_ldo_ctrl_otp_readback.sv ====
// Notes on behaviour
// R1: control bit 7 picks output voltage, 0 gives 5.0V, 1 gives 3.3V.
// R2: enable code 0x0 keeps the regulator off whatever the charger does.
// R3: enable code 0x1 turns the regulator on exactly while charger present.
// R4: code 0x2 needs charger present and the selected pin condition true.
// R5: software must never program the reserved enable code 0x3.
// R6: each pin-select bit adds its pin; selected pin levels are ORed.
// R7: a read-write eight-bit register chooses the shadow entry read back.
// R8: boot copies the whole one-time memory into the shadow file first.
// R9: the read-only data register returns the addressed entry; writes ignored.
// R10: a written reserved enable code keeps the regulator off.
`timescale 1ns/10ps
`default_nettype none

module safe_ldo_ctrl_otp_readback #(
    parameter int PIN_COUNT       = 8,
    parameter int OTP_ADDR_WIDTH  = 8,
    parameter int DATA_WIDTH      = 8
) (
    // clock and reset
    input  wire logic                      ref_clk_i,
    input  wire logic                      rstn_i,

    // register port from the serial host interface
    input  wire logic                      reg_wr_en_i,
    input  wire logic                      reg_rd_en_i,
    input  wire logic [7:0]                reg_addr_i,
    input  wire logic [DATA_WIDTH-1:0]     reg_wr_data_i,
    output logic      [DATA_WIDTH-1:0]     reg_rd_data_o,
    output logic                           reg_rd_valid_o,
    output logic                           reg_addr_hit_o,

    // pins, asynchronous to ref_clk_i
    input  wire logic                      charger_input_i,
    input  wire logic [PIN_COUNT-1:0]      multipurpose_pin_i,

    // one-time memory read port used by the boot copy
    output logic      [OTP_ADDR_WIDTH-1:0] otp_addr_o,
    output logic                           otp_rd_en_o,
    input  wire logic [DATA_WIDTH-1:0]     otp_data_i,

    // regulator controls and status
    output logic                           safe_ldo_enable_o,
    output logic                           safe_ldo_voltage_select_o,
    output logic                           boot_done_o
);

    localparam logic [OTP_ADDR_WIDTH-1:0] LAST_ENTRY = '1;

    // decode helpers
    // the regulator decision sits in one function so that every mode
    // code, the reserved one too, is decided in one place
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == safe_ldo_pkg::CONTROL_OFFSET)
                 || (addr == safe_ldo_pkg::PIN_SELECT_OFFSET)
                 || (addr == safe_ldo_pkg::OTP_ADDRESS_OFFSET)
                 || (addr == safe_ldo_pkg::OTP_DATA_OFFSET);
    endfunction

    // decide the regulator state from mode, charger and pin condition
    function automatic logic ldo_on(input logic [1:0] mode,
                                    input logic       charger,
                                    input logic       pin_cond);
        logic result;
        result = 1'b0;
        unique case (mode)
            safe_ldo_pkg::MODE_OFF:      result = 1'b0;            // [R2]
            safe_ldo_pkg::MODE_CHARGER:  result = charger;         // [R3]
            safe_ldo_pkg::MODE_PIN:      result = charger & pin_cond; // [R4]
            safe_ldo_pkg::MODE_RESERVED: result = 1'b0;            // [R10]
        endcase
        ldo_on = result;
    endfunction

    // pin synchronisers
    // a pin change reaches the enable output three cycles later
    logic                 charger_sync;
    logic [PIN_COUNT-1:0] pin_sync_lvl;

    pin_sync #(
        .WIDTH (1)
    ) u_charger_sync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .async_i   (charger_input_i),
        .sync_o    (charger_sync)
    );

    pin_sync #(
        .WIDTH (PIN_COUNT)
    ) u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .async_i   (multipurpose_pin_i),
        .sync_o    (pin_sync_lvl)
    );

    // boot copy of the one-time memory into the shadow file
    // runs once after every reset; register access may overlap it
    safe_ldo_pkg::boot_state_type boot_state_q;
    safe_ldo_pkg::boot_state_type boot_state_d;
    logic [OTP_ADDR_WIDTH-1:0]    boot_addr_q;
    logic [OTP_ADDR_WIDTH-1:0]    boot_addr_d;
    logic                         fetch_q;
    logic                         fetch_d;
    logic [OTP_ADDR_WIDTH-1:0]    fetch_addr_q;
    logic [OTP_ADDR_WIDTH-1:0]    fetch_addr_d;
    logic                         boot_done_q;
    logic                         boot_done_d;

    // the otp macro answers one cycle after its address, so the write
    // trails the fetch by one cycle and uses the captured address
    always_comb begin
        boot_state_d = boot_state_q;
        boot_addr_d  = boot_addr_q;
        fetch_d      = 1'b0;
        fetch_addr_d = boot_addr_q;
        boot_done_d  = boot_done_q;
        unique case (boot_state_q)
            safe_ldo_pkg::BOOT_IDLE: begin
                boot_state_d = safe_ldo_pkg::BOOT_COPY;
                boot_addr_d  = '0;
            end
            safe_ldo_pkg::BOOT_COPY: begin
                fetch_d = 1'b1;                                    // [R8]
                if (boot_addr_q == LAST_ENTRY) begin
                    boot_state_d = safe_ldo_pkg::BOOT_DONE;
                end else begin
                    boot_addr_d = boot_addr_q + 1'b1;
                end
            end
            safe_ldo_pkg::BOOT_DONE: begin
                // readback offered only after the last entry landed
                boot_done_d = ~fetch_q;                            // [R8]
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            boot_state_q <= safe_ldo_pkg::BOOT_IDLE;
            boot_addr_q  <= '0;
            fetch_q      <= 1'b0;
            fetch_addr_q <= '0;
            boot_done_q  <= 1'b0;
        end else begin
            boot_state_q <= boot_state_d;
            boot_addr_q  <= boot_addr_d;
            fetch_q      <= fetch_d;
            fetch_addr_q <= fetch_addr_d;
            boot_done_q  <= boot_done_d;
        end
    end

    assign otp_addr_o  = boot_addr_q;
    assign otp_rd_en_o = (boot_state_q == safe_ldo_pkg::BOOT_COPY);
    assign boot_done_o = boot_done_q;

    // software registers
    // a write lands on the edge that takes the strobe
    logic [DATA_WIDTH-1:0] control_q;
    logic [DATA_WIDTH-1:0] control_d;
    logic [PIN_COUNT-1:0]  pin_select_q;
    logic [PIN_COUNT-1:0]  pin_select_d;
    logic [OTP_ADDR_WIDTH-1:0] otp_address_q;
    logic [OTP_ADDR_WIDTH-1:0] otp_address_d;
    logic [DATA_WIDTH-1:0] shadow_rd_data;

    always_comb begin
        control_d     = control_q;
        pin_select_d  = pin_select_q;
        otp_address_d = otp_address_q;
        if (reg_wr_en_i) begin
            unique case (reg_addr_i)
                safe_ldo_pkg::CONTROL_OFFSET: begin
                    // unimplemented bits are dropped; the reserved code is
                    // stored as written and decoded as off
                    control_d = reg_wr_data_i & safe_ldo_pkg::CONTROL_MASK;
                end
                safe_ldo_pkg::PIN_SELECT_OFFSET: begin
                    pin_select_d = reg_wr_data_i[PIN_COUNT-1:0];
                end
                safe_ldo_pkg::OTP_ADDRESS_OFFSET: begin
                    otp_address_d = reg_wr_data_i[OTP_ADDR_WIDTH-1:0]; // [R7]
                end
                // the data register is read-only: a write is dropped
                safe_ldo_pkg::OTP_DATA_OFFSET: begin                // [R9]
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            control_q     <= safe_ldo_pkg::CONTROL_RESET;
            pin_select_q  <= safe_ldo_pkg::PIN_SELECT_RESET[PIN_COUNT-1:0];
            otp_address_q <= safe_ldo_pkg::OTP_ADDRESS_RESET;
        end else begin
            control_q     <= control_d;
            pin_select_q  <= pin_select_d;
            otp_address_q <= otp_address_d;
        end
    end

    // shadow file: written by boot, read at the programmed address
    otp_shadow_mem #(
        .ADDR_WIDTH (OTP_ADDR_WIDTH),
        .DATA_WIDTH (DATA_WIDTH)
    ) u_shadow (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .wr_en_i   (fetch_q),
        .wr_addr_i (fetch_addr_q),
        .wr_data_i (otp_data_i),
        .rd_addr_i (otp_address_q),                                // [R9]
        .rd_data_o (shadow_rd_data)
    );

    // register read path, answer one cycle after the request
    // read data hold between reads so that a late look still finds them
    // unchanged
    logic [DATA_WIDTH-1:0] rd_data_q;
    logic [DATA_WIDTH-1:0] rd_data_d;
    logic                  rd_valid_q;
    logic                  rd_valid_d;

    always_comb begin
        rd_data_d  = safe_ldo_pkg::UNMAPPED_DATA;
        rd_valid_d = reg_rd_en_i;
        if (reg_rd_en_i) begin
            unique case (reg_addr_i)
                safe_ldo_pkg::CONTROL_OFFSET: begin
                    rd_data_d = control_q;
                end
                safe_ldo_pkg::PIN_SELECT_OFFSET: begin
                    rd_data_d = pin_select_q;
                end
                safe_ldo_pkg::OTP_ADDRESS_OFFSET: begin
                    rd_data_d = otp_address_q;                     // [R7]
                end
                safe_ldo_pkg::OTP_DATA_OFFSET: begin
                    // entries before the copy finishes are not trusted
                    rd_data_d = boot_done_q ? shadow_rd_data
                                            : safe_ldo_pkg::UNMAPPED_DATA; // [R9]
                end
                default: begin
                    rd_data_d = safe_ldo_pkg::UNMAPPED_DATA;
                end
            endcase
        end else begin
            rd_data_d = rd_data_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_q  <= safe_ldo_pkg::READ_DATA_RESET;
            rd_valid_q <= 1'b0;
        end else begin
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign reg_rd_data_o  = rd_data_q;
    assign reg_rd_valid_o = rd_valid_q;
    assign reg_addr_hit_o = is_mapped(reg_addr_i);

    // regulator control
    // registered, so decode steps of a register write never reach the pin
    logic pin_condition;
    logic ldo_en_q;
    logic ldo_en_d;
    logic vsel_q;
    logic vsel_d;

    always_comb begin
        pin_condition = |(pin_sync_lvl & pin_select_q);            // [R6]
        ldo_en_d = ldo_on(control_q[safe_ldo_pkg::ENABLE_MODE_MSB:
                                    safe_ldo_pkg::ENABLE_MODE_LSB],
                          charger_sync, pin_condition);
        vsel_d   = control_q[safe_ldo_pkg::VOLTAGE_SELECT_BIT];    // [R1]
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ldo_en_q <= 1'b0;
            vsel_q   <= safe_ldo_pkg::VOLTAGE_5V0;
        end else begin
            ldo_en_q <= ldo_en_d;
            vsel_q   <= vsel_d;
        end
    end

    assign safe_ldo_enable_o         = ldo_en_q;
    assign safe_ldo_voltage_select_o = vsel_q;

endmodule // safe_ldo_ctrl_otp_readback

`default_nettype wire

// ==== src/safe_ldo_pkg.sv ====
package safe_ldo_pkg;

    // register offsets on the internal register port
    localparam logic [7:0] CONTROL_OFFSET      = 8'h86;
    localparam logic [7:0] PIN_SELECT_OFFSET   = 8'h87;
    localparam logic [7:0] OTP_ADDRESS_OFFSET  = 8'h88;
    localparam logic [7:0] OTP_DATA_OFFSET     = 8'h89;

    // field positions in the control register
    localparam int VOLTAGE_SELECT_BIT = 7;
    localparam int ENABLE_MODE_LSB    = 0;
    localparam int ENABLE_MODE_MSB    = 1;

    // enable mode codes
    localparam logic [1:0] MODE_OFF      = 2'h0;
    localparam logic [1:0] MODE_CHARGER  = 2'h1;
    localparam logic [1:0] MODE_PIN      = 2'h2;
    localparam logic [1:0] MODE_RESERVED = 2'h3;

    // voltage select codes
    localparam logic VOLTAGE_5V0 = 1'b0;
    localparam logic VOLTAGE_3V3 = 1'b1;

    // values after reset
    localparam logic [7:0] CONTROL_RESET     = 8'h00;
    localparam logic [7:0] PIN_SELECT_RESET  = 8'h00;
    localparam logic [7:0] OTP_ADDRESS_RESET = 8'h00;
    localparam logic [7:0] READ_DATA_RESET   = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA     = 8'h00;

    // control bits that are not implemented read as zero
    localparam logic [7:0] CONTROL_MASK = 8'h83;

    // boot copy: cycles between otp address and otp data
    localparam int OTP_READ_LATENCY = 1;

    typedef enum logic [2:0] {
        BOOT_IDLE = 3'b001,
        BOOT_COPY = 3'b010,
        BOOT_DONE = 3'b100
    } boot_state_type;

endpackage

// ==== tb/safe_ldo_ctrl_otp_readback_test.sv ====
`timescale 1ns/10ps
`default_nettype none

module safe_ldo_ctrl_otp_readback_test;
    logic       ref_clk_i = 1'b0;
    logic       rstn_i    = 1'b0;
    logic       wr_en     = 1'b0;
    logic       rd_en     = 1'b0;
    logic       chg       = 1'b0;
    logic [7:0] addr      = 8'h00;
    logic [7:0] wdata     = 8'h00;
    logic [7:0] pins      = 8'h00;
    logic [7:0] otp_data  = 8'h00;
    logic [7:0] rdata, otp_addr;
    logic       rd_valid, otp_rd_en, ldo_en, ldo_volt, boot_done, addr_hit;
    logic [7:0] otp_addr_seen = 8'h00;
    int         err_total  = 0;
    int         num_checks = 0;

    always #20 ref_clk_i = ~ref_clk_i;

    safe_ldo_ctrl_otp_readback u_dut (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_wr_en_i(wr_en),
        .reg_rd_en_i(rd_en), .reg_addr_i(addr), .reg_wr_data_i(wdata),
        .reg_rd_data_o(rdata), .reg_rd_valid_o(rd_valid),
        .reg_addr_hit_o(addr_hit), .charger_input_i(chg),
        .multipurpose_pin_i(pins), .otp_addr_o(otp_addr),
        .otp_rd_en_o(otp_rd_en), .otp_data_i(otp_data),
        .safe_ldo_enable_o(ldo_en), .safe_ldo_voltage_select_o(ldo_volt),
        .boot_done_o(boot_done)
    );

    // one-time memory content: a pattern that differs at every address
    function automatic logic [7:0] otp_word(input logic [7:0] a);
        return a ^ 8'h5a;
    endfunction

    // the macro registers its address, so data trail the address a cycle
    always @(posedge ref_clk_i) begin
        if (otp_rd_en) begin
            otp_addr_seen <= otp_addr;
        end
    end

    always @(negedge ref_clk_i) otp_data <= otp_word(otp_addr_seen);

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        wr_en = 1'b1;
        addr  = a;
        wdata = d;
        @(negedge ref_clk_i);
        wr_en = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk_i);
        rd_en = 1'b1;
        addr  = a;
        @(negedge ref_clk_i);
        rd_en = 1'b0;
        chk({7'h0, rd_valid}, 8'h01);
        chk({7'h0, addr_hit}, {7'h0, (a >= 8'h86 && a <= 8'h89)});
        chk(rdata, exp);
    endtask

    // pins pass two sync flops and one output flop, so five cycles is ample
    task automatic en_chk(input logic c, input logic [7:0] p, input logic e);
        @(negedge ref_clk_i);
        chg  = c;
        pins = p;
        repeat (5) @(negedge ref_clk_i);
        chk({7'h0, ldo_en}, {7'h0, e});
    endtask

    task automatic t_reset;
        chk({7'h0, boot_done}, 8'h00);
        rd_chk(8'h89, 8'h00);
        rd_chk(8'h86, 8'h00);
        rd_chk(8'h87, 8'h00);
        rd_chk(8'h88, 8'h00);
        chk({6'h0, ldo_en, ldo_volt}, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_otp;
        logic [7:0] al [4] = '{8'h00, 8'h01, 8'h7e, 8'hff};
        for (int i = 0; i < 400 && boot_done !== 1'b1; i++) begin
            @(negedge ref_clk_i);
        end
        chk({7'h0, boot_done}, 8'h01);
        foreach (al[i]) begin
            reg_wr(8'h88, al[i]);
            rd_chk(8'h88, al[i]);
            rd_chk(8'h89, otp_word(al[i]));
        end
        reg_wr(8'h89, 8'hc3);
        rd_chk(8'h89, otp_word(8'hff));
        rd_chk(8'h88, 8'hff);
        $display("test otp readback done");
    endtask

    task automatic t_control;
        reg_wr(8'h86, 8'hff);
        rd_chk(8'h86, 8'h83);
        en_chk(1'b1, 8'hff, 1'b0);
        chk({7'h0, ldo_volt}, 8'h01);
        reg_wr(8'h86, 8'h7c);
        rd_chk(8'h86, 8'h00);
        en_chk(1'b1, 8'hff, 1'b0);
        chk({7'h0, ldo_volt}, 8'h00);
        reg_wr(8'h86, 8'h81);
        en_chk(1'b1, 8'h00, 1'b1);
        en_chk(1'b0, 8'hff, 1'b0);
        en_chk(1'b1, 8'hff, 1'b1);
        $display("test control modes done");
    endtask

    task automatic t_pins;
        reg_wr(8'h86, 8'h02);
        for (int n = 0; n < 8; n++) begin
            reg_wr(8'h87, 8'h01 << n);
            rd_chk(8'h87, 8'h01 << n);
            en_chk(1'b1, 8'h01 << n, 1'b1);
            en_chk(1'b1, ~(8'h01 << n), 1'b0);
        end
        reg_wr(8'h87, 8'h81);
        en_chk(1'b1, 8'h80, 1'b1);
        en_chk(1'b0, 8'h81, 1'b0);
        reg_wr(8'h87, 8'h00);
        en_chk(1'b1, 8'hff, 1'b0);
        reg_wr(8'h86, 8'h03);
        en_chk(1'b1, 8'hff, 1'b0);
        $display("test pin gating done");
    endtask

    task automatic t_unmapped;
        reg_wr(8'h85, 8'h55);
        rd_chk(8'h85, 8'h00);
        rd_chk(8'h8a, 8'h00);
        rd_chk(8'h86, 8'h03);
        $display("test unmapped done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        t_reset;
        t_otp;
        t_control;
        t_pins;
        t_unmapped;
        wrap_up;
    end

    // the whole sequence needs about 500 cycles
    initial begin
        #(40 * 5000);
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        wrap_up;
    end
endmodule // safe_ldo_ctrl_otp_readback_test

`default_nettype wire

// ==== tb/safe_ldo_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none

module safe_ldo_monitor #(
    parameter int PIN_COUNT      = 8,
    parameter int OTP_ADDR_WIDTH = 8,
    parameter int DATA_WIDTH     = 8
) (
    // clock and reset
    input wire logic                      ref_clk_i,
    input wire logic                      rstn_i,
    // register port
    input wire logic                      reg_wr_en_i,
    input wire logic                      reg_rd_en_i,
    input wire logic [7:0]                reg_addr_i,
    input wire logic [DATA_WIDTH-1:0]     reg_wr_data_i,
    input wire logic [DATA_WIDTH-1:0]     reg_rd_data_o,
    input wire logic                      reg_rd_valid_o,
    // pins and outputs
    input wire logic                      charger_input_i,
    input wire logic [PIN_COUNT-1:0]      multipurpose_pin_i,
    input wire logic [OTP_ADDR_WIDTH-1:0] otp_addr_o,
    input wire logic                      otp_rd_en_o,
    input wire logic                      safe_ldo_enable_o,
    input wire logic                      safe_ldo_voltage_select_o,
    input wire logic                      boot_done_o
);
    logic [7:0] ctrl_d, ctrl_q, sel_d, sel_q, adr_d, adr_q;
    logic       rd_ok;

    // shadow copies of the writable registers, taken from the port traffic
    always_comb begin
        ctrl_d = ctrl_q;
        sel_d  = sel_q;
        adr_d  = adr_q;
        if (reg_wr_en_i && reg_addr_i == safe_ldo_pkg::CONTROL_OFFSET) begin
            ctrl_d = reg_wr_data_i & safe_ldo_pkg::CONTROL_MASK;
        end
        if (reg_wr_en_i && reg_addr_i == safe_ldo_pkg::PIN_SELECT_OFFSET) begin
            sel_d = reg_wr_data_i;
        end
        if (reg_wr_en_i && reg_addr_i == safe_ldo_pkg::OTP_ADDRESS_OFFSET) begin
            adr_d = reg_wr_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_q <= 8'h00;
            sel_q  <= 8'h00;
            adr_q  <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
            sel_q  <= sel_d;
            adr_q  <= adr_d;
        end
    end

    // a read that collides with a write is left unjudged by the three register readback checks
    assign rd_ok = reg_rd_en_i && !reg_wr_en_i;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    a_volt_select_follow: assert property (
        safe_ldo_voltage_select_o == $past(ctrl_q[7]))
        else $error("voltage select does not follow control bit");
    a_mode_off_low: assert property (
        $past(ctrl_q[1:0]) == safe_ldo_pkg::MODE_OFF |-> !safe_ldo_enable_o)
        else $error("regulator on in disabled mode");
    a_charger_mode_follow: assert property (
        $past(ctrl_q[1:0]) == safe_ldo_pkg::MODE_CHARGER
        |-> safe_ldo_enable_o == $past(charger_input_i, 3))
        else $error("enable does not follow charger");
    a_pin_mode_gate: assert property (
        $past(ctrl_q[1:0]) == safe_ldo_pkg::MODE_PIN
        |-> safe_ldo_enable_o == ($past(charger_input_i, 3)
        && |($past(multipurpose_pin_i, 3) & $past(sel_q))))
        else $error("enable wrong in pin mode");
    a_reserved_mode_low: assert property (
        $past(ctrl_q[1:0]) == safe_ldo_pkg::MODE_RESERVED |-> !safe_ldo_enable_o)
        else $error("regulator on in reserved mode");
    a_ctrl_read_back: assert property (
        rd_ok && reg_addr_i == safe_ldo_pkg::CONTROL_OFFSET
        |=> reg_rd_valid_o && reg_rd_data_o == $past(ctrl_q))
        else $error("control readback wrong");
    a_sel_read_back: assert property (
        rd_ok && reg_addr_i == safe_ldo_pkg::PIN_SELECT_OFFSET
        |=> reg_rd_data_o == $past(sel_q))
        else $error("pin select readback wrong");
    a_addr_read_back: assert property (
        rd_ok && reg_addr_i == safe_ldo_pkg::OTP_ADDRESS_OFFSET
        |=> reg_rd_data_o == $past(adr_q))
        else $error("readback address wrong");
    a_data_before_boot: assert property (
        reg_rd_en_i && reg_addr_i == safe_ldo_pkg::OTP_DATA_OFFSET
        && !boot_done_o |=> reg_rd_data_o == 8'h00)
        else $error("shadow data offered before boot copy");
    a_boot_done_sticky: assert property (
        boot_done_o |=> boot_done_o)
        else $error("boot done dropped");
    a_otp_walk_step: assert property (
        otp_rd_en_o && $past(otp_rd_en_o) |-> otp_addr_o == $past(otp_addr_o) + 8'h01)
        else $error("boot copy skipped an address");
    a_read_hold_data: assert property (
        !reg_rd_en_i |=> !reg_rd_valid_o && $stable(reg_rd_data_o))
        else $error("read data moved without a read");
endmodule // safe_ldo_monitor

bind safe_ldo_ctrl_otp_readback safe_ldo_monitor #(
    .PIN_COUNT(PIN_COUNT), .OTP_ADDR_WIDTH(OTP_ADDR_WIDTH),
    .DATA_WIDTH(DATA_WIDTH)
) u_mon (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_wr_en_i(reg_wr_en_i),
    .reg_rd_en_i(reg_rd_en_i), .reg_addr_i(reg_addr_i),
    .reg_wr_data_i(reg_wr_data_i), .reg_rd_data_o(reg_rd_data_o),
    .reg_rd_valid_o(reg_rd_valid_o), .charger_input_i(charger_input_i),
    .multipurpose_pin_i(multipurpose_pin_i), .otp_addr_o(otp_addr_o),
    .otp_rd_en_o(otp_rd_en_o), .safe_ldo_enable_o(safe_ldo_enable_o),
    .safe_ldo_voltage_select_o(safe_ldo_voltage_select_o),
    .boot_done_o(boot_done_o)
);

`default_nettype wire
